// ---- hw/acr_converter_control.sv ----
// Register and sequencing logic of the ten-bit converter control block.
`timescale 1ns/10ps
module acr_converter_control (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Register port.
   input  wire logic [7:0] regAddr,        // Register offset.
   input  wire logic [7:0] regWrData,      // Write data.
   input  wire logic       regWrite,       // Write strobe.
   input  wire logic       regRead,        // Read strobe.
   output logic [7:0]      regRdData,      // Read data, one cycle after the strobe.
   // Processor side.
   input  wire logic       globalIntEn,    // Global interrupt enable.
   input  wire logic       vectorTaken,    // Interrupt vector taken.
   input  wire logic [7:0] triggerSources, // Trigger flags, index is source code.
   output logic            irqRequest,     // Conversion complete request.
   // Analog front end.
   input  wire logic [9:0] sampleData,     // Value of the finished conversion.
   output logic            converterOn,    // Analog part powered.
   output logic            convActive,     // Conversion in progress.
   output logic            refSupply,      // One selects the supply pin reference.
   output logic [3:0]      channelSel,     // Applied channel code.
   output logic [1:0]      routeClass,     // Routing class of applied channel.
   output logic            convTick        // One converter clock tick.
);
   // ==========================================================================
   // Declarations.
   // ==========================================================================
   typedef enum logic [1:0] {IDLE, CONVERT} acr_state_t;   // Sequencer states.
   acr_state_t state_r;            // Sequencer state.
   logic [7:0] selectReg_r;        // Written select register.
   logic [7:0] ctrlA_r;            // Control A bits except start and flag.
   logic [7:0] ctrlB_r;            // Control B register.
   logic       flag_r;             // Completion flag.
   logic       needInit_r;         // Next conversion initialises.
   logic [4:0] cycles_r;           // Converter cycles left.
   logic       refApplied_r;       // Reference in force.
   logic [3:0] chanApplied_r;      // Channel in force.
   logic       trigPrev_r;         // Trigger level one cycle ago.
   logic       freeRestart_r;      // Free running relaunch pending.
   logic       tick;               // Prescaler tick.
   logic [9:0] result;             // Stored result.
   logic       wrSel, wrA, wrB;    // Write decodes.
   logic       startReq;           // Launch request this cycle.
   logic       done;               // Conversion ends this cycle.
   logic       trigLevel;          // Selected trigger level.
   logic       enNow;              // Enable after this cycle's write.
   logic [7:0] readMux;            // Read data before the register.

   // Decode a read or write access to a given offset.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Routing class of a channel code.
   function automatic logic [1:0] route(input logic [3:0] ch);
      if (ch < acr_pkg::CH_TEMP) begin
         return 2'(acr_pkg::ROUTE_PIN);
      end else if (ch == acr_pkg::CH_TEMP) begin
         return 2'(acr_pkg::ROUTE_SENSOR);
      end else if (ch == acr_pkg::CH_BANDGAP || ch == acr_pkg::CH_GROUND) begin
         return 2'(acr_pkg::ROUTE_FIXED);
      end else begin
         return 2'(acr_pkg::ROUTE_NONE);
      end
   endfunction

   assign wrSel = regWrite && hit(regAddr, acr_pkg::SELECT_OFS);
   assign wrA   = regWrite && hit(regAddr, acr_pkg::CTRL_A_OFS);
   assign wrB   = regWrite && hit(regAddr, acr_pkg::CTRL_B_OFS);
   assign enNow = wrA ? regWrData[acr_pkg::EN_BIT] : ctrlA_r[acr_pkg::EN_BIT];

   // ==========================================================================
   // Submodules.
   // ==========================================================================
   // Converter clock divider.
   acr_prescaler uPrescaler (
      .clk       (clk),
      .reset_n   (reset_n),
      .run       (ctrlA_r[acr_pkg::EN_BIT]),
      .divSelect (ctrlA_r[2:0]),
      .tick      (tick)
   );

   // Result store with low byte lock.
   acr_result_store uResult (
      .clk      (clk),
      .reset_n  (reset_n),
      .load     (done),
      .newValue (sampleData),
      .lowRead  (regRead && hit(regAddr, acr_pkg::RESULT_LOW_OFS)),
      .highRead (regRead && hit(regAddr, acr_pkg::RESULT_HIGH_OFS)),
      .value    (result)
   );

   // ==========================================================================
   // Control registers.
   // ==========================================================================
   // Writable control bits; start and flag are handled separately.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrlA_r     <= acr_pkg::RESET_VAL;
         ctrlB_r     <= acr_pkg::RESET_VAL;
         selectReg_r <= acr_pkg::RESET_VAL;
      end else begin
         if (wrA) begin
            ctrlA_r <= regWrData;
         end
         if (wrB) begin
            ctrlB_r <= regWrData & acr_pkg::CTRL_B_MASK;
         end
         if (wrSel) begin
            selectReg_r <= regWrData & acr_pkg::SELECT_MASK;
         end
      end
   end

   // ==========================================================================
   // Triggering.
   // ==========================================================================
   // select source by code.
   assign trigLevel = triggerSources[ctrlB_r[2:0]];

   // Previous trigger level, taken through the source switch.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         trigPrev_r <= 1'b0;
      end else begin
         trigPrev_r <= trigLevel;
      end
   end

   // Launch when idle and enabled on a write, an edge or a free running relaunch.
   always_comb begin
      startReq = 1'b0;
      if (enNow && state_r == IDLE) begin
         if (wrA && regWrData[acr_pkg::START_BIT]) begin
            startReq = 1'b1;
         end
         if (ctrlA_r[acr_pkg::AUTO_BIT] && ctrlB_r[2:0] != acr_pkg::TRIG_FREE
             && trigLevel && !trigPrev_r) begin
            startReq = 1'b1;
         end
         if (freeRestart_r) begin
            startReq = 1'b1;
         end
      end
   end

   // ==========================================================================
   // Sequencer.
   // ==========================================================================
   assign done = (state_r == CONVERT) && tick && (cycles_r == 5'd1);

   // Conversion state, cycle count and initialisation marker.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r    <= IDLE;
         cycles_r   <= 5'd0;
         needInit_r <= 1'b1;
      end else if (!enNow) begin
         state_r    <= IDLE;
         cycles_r   <= 5'd0;
         needInit_r <= 1'b1;
      end else begin
         case (state_r)
            IDLE: begin
               if (startReq) begin
                  state_r    <= CONVERT;
                  cycles_r   <= needInit_r ? acr_pkg::FIRST_CYCLES : acr_pkg::NORMAL_CYCLES;
                  needInit_r <= 1'b0;
               end
            end
            CONVERT: begin
               if (tick) begin
                  cycles_r <= cycles_r - 5'd1;
                  if (cycles_r == 5'd1) begin
                     state_r <= IDLE;
                  end
               end
            end
            default: begin
               state_r <= IDLE;
            end
         endcase
      end
   end

   // Free running relaunch after each completion.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         freeRestart_r <= 1'b0;
      end else begin
         freeRestart_r <= done && ctrlA_r[acr_pkg::AUTO_BIT]
                          && ctrlB_r[2:0] == acr_pkg::TRIG_FREE;
      end
   end

   // ==========================================================================
   // Completion flag.
   // ==========================================================================
   // set wins over both clears.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flag_r <= 1'b0;
      end else if (done) begin
         flag_r <= 1'b1;
      end else if (vectorTaken || (wrA && regWrData[acr_pkg::FLAG_BIT])) begin
         flag_r <= 1'b0;
      end
   end

   // ==========================================================================
   // Applied reference and channel.
   // ==========================================================================
   // apply only when idle.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         refApplied_r  <= 1'b0;
         chanApplied_r <= 4'h0;
      end else if (state_r == IDLE) begin
         refApplied_r  <= selectReg_r[acr_pkg::REF_BIT];
         chanApplied_r <= selectReg_r[3:0];
      end
   end

   // ==========================================================================
   // Outputs.
   // ==========================================================================
   // Front end controls, all registered.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         converterOn <= 1'b0;
         convActive  <= 1'b0;
         refSupply   <= 1'b0;
         channelSel  <= 4'h0;
         routeClass  <= 2'(acr_pkg::ROUTE_PIN);
         convTick    <= 1'b0;
         irqRequest  <= 1'b0;
      end else begin
         converterOn <= ctrlA_r[acr_pkg::EN_BIT];
         convActive  <= state_r == CONVERT;
         refSupply   <= refApplied_r;
         channelSel  <= chanApplied_r;
         routeClass  <= route(chanApplied_r);
         convTick    <= tick;
         irqRequest  <= flag_r && ctrlA_r[acr_pkg::IE_BIT] && globalIntEn;
      end
   end

   // ==========================================================================
   // Read path.
   // ==========================================================================
   always_comb begin
      readMux = 8'h00;
      if (hit(regAddr, acr_pkg::RESULT_LOW_OFS)) begin
         readMux = selectReg_r[acr_pkg::ALIGN_BIT] ? {result[1:0], 6'h00} : result[7:0];
      end else if (hit(regAddr, acr_pkg::RESULT_HIGH_OFS)) begin
         readMux = selectReg_r[acr_pkg::ALIGN_BIT] ? result[9:2] : {6'h00, result[9:8]};
      end else if (hit(regAddr, acr_pkg::CTRL_A_OFS)) begin
         readMux = {ctrlA_r[7], state_r == CONVERT, ctrlA_r[5], flag_r, ctrlA_r[3:0]};
      end else if (hit(regAddr, acr_pkg::CTRL_B_OFS)) begin
         readMux = ctrlB_r;
      end else if (hit(regAddr, acr_pkg::SELECT_OFS)) begin
         readMux = selectReg_r;
      end
   end

   // Read data register, valid one cycle after the strobe, zero otherwise.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= regRead ? readMux : 8'h00;
      end
   end
endmodule : acr_converter_control

// ---- hw/acr_pkg.sv ----
// Package with register map, field positions and timing constants of the converter control block.
package acr_pkg;
   // ==========================================================================
   // Register offsets.
   // ==========================================================================
   localparam logic [7:0] RESULT_LOW_OFS  = 8'h78;   // Result low byte.
   localparam logic [7:0] RESULT_HIGH_OFS = 8'h79;   // Result high byte.
   localparam logic [7:0] CTRL_A_OFS      = 8'h7A;   // Converter control A.
   localparam logic [7:0] CTRL_B_OFS      = 8'h7B;   // Converter control B.
   localparam logic [7:0] SELECT_OFS      = 8'h7C;   // Input and reference select.
   // ==========================================================================
   // Field positions.
   // ==========================================================================
   localparam int EN_BIT    = 7;   // Converter enable.
   localparam int START_BIT = 6;   // Start conversion.
   localparam int AUTO_BIT  = 5;   // Auto trigger enable.
   localparam int FLAG_BIT  = 4;   // Completion flag.
   localparam int IE_BIT    = 3;   // Completion interrupt enable.
   localparam int REF_BIT   = 6;   // Reference select.
   localparam int ALIGN_BIT = 5;   // Result alignment.
   localparam logic [7:0] SELECT_MASK = 8'h6F;   // Writable select bits.
   localparam logic [7:0] CTRL_B_MASK = 8'h47;   // Writable control B bits.
   localparam logic [7:0] RESET_VAL   = 8'h00;   // Reset value of the control and select registers.
   // ==========================================================================
   // Channel codes and timing.
   // ==========================================================================
   localparam logic [3:0] CH_TEMP    = 4'h8;   // Temperature sensor channel.
   localparam logic [3:0] CH_BANDGAP = 4'hE;   // Bandgap channel.
   localparam logic [3:0] CH_GROUND  = 4'hF;   // Ground channel.
   localparam logic [2:0] TRIG_FREE  = 3'h0;   // Free running trigger source.
   localparam logic [4:0] FIRST_CYCLES  = 5'd25;   // Initialising conversion length.
   localparam logic [4:0] NORMAL_CYCLES = 5'd13;   // Normal conversion length.
   localparam logic [9:0] RESULT_RESET  = 10'h000;   // Result reset value.
   // Channel routing class.
   typedef enum logic [1:0] {ROUTE_PIN, ROUTE_SENSOR, ROUTE_FIXED, ROUTE_NONE} acr_route_t;
endpackage : acr_pkg

// ---- hw/acr_prescaler.sv ----
// Prescaler that makes the converter clock tick from the system clock.
`timescale 1ns/10ps
module acr_prescaler (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Control.
   input  wire logic       run,        // Converter enabled.
   input  wire logic [2:0] divSelect,  // Prescaler select field.
   // Tick out.
   output logic            tick        // One pulse each converter clock.
);
   logic [6:0] count_r;   // Free count while enabled.
   logic [6:0] mask;      // Divider minus one.

   // Codes 0 and 1 both divide by two, the rest by two to the code.
   always_comb begin
      if (divSelect == 3'h0) begin
         mask = 7'h01;
      end else begin
         mask = 7'((8'h01 << divSelect) - 8'h01);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || !run) begin
         count_r <= 7'h00;
         tick    <= 1'b0;
      end else begin
         count_r <= count_r + 7'h01;
         tick    <= ((count_r & mask) == mask);
      end
   end
endmodule : acr_prescaler

// ---- hw/acr_result_store.sv ----
// Result store with read lock for the ten-bit conversion result.
`timescale 1ns/10ps
module acr_result_store (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Update side.
   input  wire logic       load,       // Conversion finished.
   input  wire logic [9:0] newValue,   // Finished result.
   // Read side.
   input  wire logic       lowRead,    // Low byte read.
   input  wire logic       highRead,   // High byte read.
   output logic [9:0]      value       // Stored result.
);
   logic locked_r;   // Low byte read, high byte not yet.

   // lock from low read to high read.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         locked_r <= 1'b0;
      end else if (highRead) begin
         locked_r <= 1'b0;
      end else if (lowRead) begin
         locked_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         value <= acr_pkg::RESULT_RESET;
      end else if (load && !locked_r) begin
         value <= newValue;
      end
   end
endmodule : acr_result_store

// ---- testbench/acr_checker.sv ----
// Checker of port relations of the converter control block.
`timescale 1ns/10ps
module acr_checker (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       reset_n,
   // Register port.
   input wire logic [7:0] regAddr,
   input wire logic       regRead,
   input wire logic [7:0] regRdData,
   // Processor and front end side.
   input wire logic       globalIntEn,
   input wire logic       irqRequest,
   input wire logic       converterOn,
   input wire logic       convActive,
   input wire logic       refSupply,
   input wire logic [3:0] channelSel,
   input wire logic [1:0] routeClass,
   input wire logic       convTick
);
   // All checks use the system clock and sleep during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // =====================================================================
   // Assertions.
   // =====================================================================
   chk_read_idle:
      assert property (!$past(regRead) |-> regRdData == 8'h00)
      else $error("read data outside its slot");
   chk_select_res:
      assert property ($past(regRead) && $past(regAddr) == acr_pkg::SELECT_OFS
         |-> (regRdData & ~acr_pkg::SELECT_MASK) == 8'h00)
      else $error("select reserved bits not zero");
   chk_ctrlb_res:
      assert property ($past(regRead) && $past(regAddr) == acr_pkg::CTRL_B_OFS
         |-> (regRdData & ~acr_pkg::CTRL_B_MASK) == 8'h00)
      else $error("control B reserved bits not zero");
   chk_off_abort:
      assert property (!converterOn && $past(converterOn == 1'b0) |-> !convActive)
      else $error("conversion runs while disabled");
   chk_tick_off:
      assert property (!converterOn && $past(converterOn == 1'b0) |-> !convTick)
      else $error("prescaler ticks while disabled");
   chk_tick_gap:
      assert property (convTick |=> !convTick)
      else $error("ticks closer than two clocks");
   chk_irq_gate:
      assert property (irqRequest |-> $past(globalIntEn))
      else $error("request without global enable");
   chk_select_hold:
      assert property (!$stable(channelSel) || !$stable(refSupply)
         |-> !($past(convActive) && $past(convActive, 2)))
      else $error("select applied during conversion");
   chk_route_map:
      assert property (routeClass == ((channelSel < 4'h8) ? 2'h0 :
         (channelSel == 4'h8) ? 2'h1 : (channelSel >= 4'hE) ? 2'h2 : 2'h3))
      else $error("routing class wrong for channel");
endmodule // acr_checker

bind acr_converter_control acr_checker i_chk (
   .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regRead(regRead),
   .regRdData(regRdData), .globalIntEn(globalIntEn), .irqRequest(irqRequest),
   .converterOn(converterOn), .convActive(convActive), .refSupply(refSupply),
   .channelSel(channelSel), .routeClass(routeClass), .convTick(convTick)
);

// ---- testbench/acr_core_model.sv ----
// Processor core model that drives the register port.
`timescale 1ns/10ps
module acr_core_model (
   // Clock.
   input wire logic       clk,
   // Register port.
   output logic [7:0]     regAddr,
   output logic [7:0]     regWrData,
   output logic           regWrite,
   output logic           regRead,
   input wire logic [7:0] regRdData
);
   // The bus idles with both strobes low.
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // One write cycle, then a quiet cycle so strobes never merge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      @(posedge clk);
   endtask
   // One read cycle; data is taken in the slot after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(posedge clk);
      d = regRdData;
   endtask
endmodule // acr_core_model

// ---- testbench/acr_converter_control_bench.sv ----
// Self-checking bench of the converter control block.
`timescale 1ns/10ps
module acr_converter_control_bench;
   logic       clk = 1'b0, reset_n = 1'b0, globalIntEn = 1'b0, vectorTaken = 1'b0;
   logic [7:0] triggerSources = 8'h00, regAddr, regWrData, regRdData, d;
   logic       regWrite, regRead, irqRequest, converterOn, convActive;
   logic       refSupply, convTick;
   logic [3:0] channelSel;
   logic [1:0] routeClass;
   logic [9:0] sampleData = 10'h000;
   int         err_count = 0, tests_run = 0, cycles = 0, curLen = 0;
   int         lastLen = 0, doneCount = 0, i, n, gap;
   // Table rows: address, written value, value read back.
   logic [7:0]  tAddr [6] = '{8'h7C, 8'h7B, 8'h7A, 8'h7D, 8'h78, 8'h79};
   logic [7:0]  tData [6] = '{8'hFF, 8'h47, 8'h07, 8'h5A, 8'h33, 8'h44};
   logic [7:0]  tExp  [6] = '{8'h6F, 8'h47, 8'h07, 8'h00, 8'h00, 8'h00};
   logic [15:0] gapExp [8] = '{16'h0002, 16'h0002, 16'h0004, 16'h0008,
                              16'h0010, 16'h0020, 16'h0040, 16'h0080};
   always #5 clk = ~clk;
   acr_core_model i_core (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
   acr_converter_control i_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .globalIntEn(globalIntEn), .vectorTaken(vectorTaken),
      .triggerSources(triggerSources), .irqRequest(irqRequest),
      .sampleData(sampleData), .converterOn(converterOn), .convActive(convActive),
      .refSupply(refSupply), .channelSel(channelSel), .routeClass(routeClass),
      .convTick(convTick));
   // Measures conversion lengths, counts completions and cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (convActive === 1'b1) curLen <= curLen + 1;
      else if (curLen != 0) begin
         lastLen <= curLen;
         doneCount <= doneCount + 1;
         curLen <= 0;
      end
      if (cycles > 6000) begin
         err_count++;
         stop_test;
      end
   end
   // Compares one value and reports a difference.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Reads one register and compares it.
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] v;
      i_core.rd(a, v);
      chk({8'h00, v}, {8'h00, exp}, what);
   endtask
   // Waits for a conversion to start and end, with bounds.
   task automatic waitConv;
      int g;
      g = 0;
      while (convActive !== 1'b1 && g < 200) begin
         @(posedge clk);
         g++;
      end
      while (convActive === 1'b1 && g < 400) begin
         @(posedge clk);
         g++;
      end
      repeat (2) @(posedge clk);
   endtask
   // Checks the last conversion length in clocks, divider two.
   task automatic chkLen(input int exp);
      chk({15'h0000, lastLen >= exp - 3 && lastLen <= exp + 3}, 16'h0001, "length");
   endtask
   // Expected routing class of a channel code.
   function automatic logic [1:0] cls(input logic [3:0] c);
      if (c < 4'h8) return 2'h0;
      if (c == 4'h8) return 2'h1;
      return (c >= 4'hE) ? 2'h2 : 2'h3;
   endfunction
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 6; i++) begin
         rdChk(tAddr[i], 8'h00, "reset value");
         i_core.wr(tAddr[i], tData[i]);
         rdChk(tAddr[i], tExp[i], "read back");
      end
      for (i = 0; i < 8; i++) begin
         i_core.wr(8'h7A, 8'h80 | i[7:0]);
         tickGap(gap);
         chk(gap[15:0], gapExp[i], "tick gap");
         i_core.wr(8'h7A, 8'h00);
      end
      for (i = 0; i < 16; i++) begin
         i_core.wr(8'h7C, {1'b0, i[0], 2'b00, i[3:0]});
         // The applied select reaches the pins two clocks after the write lands.
         repeat (2) @(posedge clk);
         chk({9'h000, refSupply, routeClass, channelSel},
             {9'h000, i[0], cls(i[3:0]), i[3:0]}, "select");
      end
      sampleData <= 10'h2B5;
      i_core.wr(8'h7A, 8'hC8);
      rdChk(8'h7A, 8'hC8, "start busy");
      chk({15'h0000, converterOn}, 16'h0001, "converter on");
      i_core.wr(8'h7C, 8'h05);
      // Give a wrongly applied select time to reach the pins.
      repeat (2) @(posedge clk);
      chk({12'h000, channelSel}, 16'h000F, "held channel");
      i_core.wr(8'h7A, 8'h88);
      chk({15'h0000, convActive}, 16'h0001, "start zero");
      waitConv;
      chkLen(50);
      chk({12'h000, channelSel}, 16'h0005, "applied channel");
      rdChk(8'h7A, 8'h98, "flag set");
      chk({15'h0000, irqRequest}, 16'h0000, "masked request");
      globalIntEn <= 1'b1;
      repeat (2) @(posedge clk);
      chk({15'h0000, irqRequest}, 16'h0001, "request");
      vectorTaken <= 1'b1;
      @(posedge clk);
      vectorTaken <= 1'b0;
      repeat (2) @(posedge clk);
      chk({15'h0000, irqRequest}, 16'h0000, "request cleared");
      globalIntEn <= 1'b0;
      rdChk(8'h78, 8'hB5, "low right");
      rdChk(8'h79, 8'h02, "high right");
      i_core.wr(8'h7C, 8'h25);
      rdChk(8'h78, 8'h40, "low left");
      rdChk(8'h79, 8'hAD, "high left");
      sampleData <= 10'h155;
      i_core.rd(8'h78, d);
      i_core.wr(8'h7A, 8'hC8);
      waitConv;
      chkLen(26);
      rdChk(8'h7A, 8'h98, "flag while locked");
      rdChk(8'h79, 8'hAD, "locked high");
      i_core.wr(8'h7A, 8'hD8);
      i_core.wr(8'h7C, 8'h05);
      rdChk(8'h79, 8'h02, "align in flight");
      waitConv;
      rdChk(8'h78, 8'h55, "new low");
      rdChk(8'h79, 8'h01, "new high");
      i_core.wr(8'h7A, 8'hD8);
      repeat (4) @(posedge clk);
      i_core.wr(8'h7A, 8'h00);
      // The busy output is registered, so it drops one clock after the state.
      @(posedge clk);
      chk({15'h0000, convActive}, 16'h0000, "aborted");
      rdChk(8'h7A, 8'h00, "no flag on abort");
      i_core.wr(8'h7A, 8'hA0);
      for (i = 1; i < 8; i++) begin
         i_core.wr(8'h7B, i[7:0]);
         n = doneCount;
         triggerSources <= 8'h01 << i;
         waitConv;
         triggerSources <= 8'h00;
         chk(16'(doneCount - n), 16'h0001, "trigger");
      end
      i_core.wr(8'h7B, 8'h01);
      triggerSources <= 8'h08;
      n = doneCount;
      i_core.wr(8'h7B, 8'h03);
      waitConv;
      chk(16'(doneCount - n), 16'h0001, "source switch");
      i_core.wr(8'h7B, 8'h00);
      repeat (40) @(posedge clk);
      chk(16'(doneCount - n), 16'h0001, "free switch");
      triggerSources <= 8'h00;
      i_core.wr(8'h7A, 8'hE0);
      waitConv;
      waitConv;
      chk(16'(doneCount - n), 16'h0003, "free running");
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdChk(8'h7A, 8'h00, "control after reset");
      rdChk(8'h7C, 8'h00, "select after reset");
      chk({15'h0000, converterOn}, 16'h0000, "off after reset");
      stop_test;
   end
   // Measures the spacing of converter clock ticks.
   task automatic tickGap(output int g);
      int w;
      w = 0;
      while (convTick !== 1'b1 && w < 300) begin
         @(posedge clk);
         w++;
      end
      g = 0;
      do begin
         @(posedge clk);
         g++;
      end while (convTick !== 1'b1 && g < 300);
   endtask
endmodule // acr_converter_control_bench
